// File: verilog/cbt_top.sv
`timescale 1ns/1ps
// Functional notes
// RQ1: in sleep with filter mode set, short dominant glitches do not wake the block
// RQ2: a valid received frame starts a one-bit-time timer link pulse right after EOF
// RQ3: a successfully transmitted frame raises the same timer link pulse
// RQ4: timer link output only follows the pulse while the link enable bit is set
// RQ5: clock source select picks oscillator or PLL tick as module clock
// RQ6: prescaler divides module clock into time quanta; bit rate is quanta per bit
// RQ7: every bit starts with a sync segment of exactly one quantum
// RQ8: segment one is programmable from 4 to 16 quanta
// RQ9: segment two is programmable from 2 to 8 quanta
// RQ10: jump width is programmable from 1 to 4 quanta
// RQ11: each timing field holds length minus one; software keeps jump width within segment two
// RQ12: new transmit bit goes onto the bus at the transmit point
// RQ13: bus is sampled at the sample point; triple sampling takes a majority vote over the last three samples
// RQ14: timing logic covers bus rates from 10 kbps to 1 Mbps
// RQ15: a 128-entry window aligned to its own size is decoded
// RQ16: window holds control, error counter, filter, receive and transmit buffer areas
// RQ17: after wake-up, wait for 11 recessive bits before joining the bus
// RQ18: sample point ends segment one; transmit point ends the sync segment
module cbt_top
    import cbt_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PRE_W = 6
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic osc_tick,
    input wire logic pll_tick,
    input wire logic can_receive_pin,
    input wire logic internal_sleep,
    input wire logic tx_active,
    input wire logic tx_bit,
    input wire logic frame_ok_rx,
    input wire logic frame_ok_tx,
    output logic can_transmit,
    output logic sample_strobe,
    output logic sampled_bit,
    output logic bus_synced,
    output logic timer_link_out,
    output logic wakeup
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] mc0;
        logic [7:0] mc1;
        logic [7:0] bt0;
        logic [7:0] bt1;
        logic [127:0][7:0] mem;
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
        logic [PRE_W-1:0] pre_cnt;
        cbt_seg_t seg;
        logic [4:0] tq_cnt;
        logic [4:0] seg_len;
        logic resynced;
        logic [1:0] samp_sh;
        logic sampled;
        logic sample_pulse;
        logic can_tx;
        logic [3:0] idle_cnt;
        logic synced;
        logic link_act;
        logic [4:0] link_cnt;
        logic timer_link_out;
    } cbt_state_t;

    cbt_state_t s_reg;
    cbt_state_t s_next;

    logic halt;
    logic src_tick;
    logic tq_tick;
    logic rx_edge;
    logic [PRE_W-1:0] presc;
    logic [3:0] time_segment_one_field;
    logic [2:0] time_segment_two_field;
    logic [4:0] sjwq;
    logic [4:0] bit_quanta;
    logic frame_seen;
    logic [6:0] widx;
    logic [6:0] ridx;

    // the upper address bits must be zero: the window sits on a 128-entry boundary
    function automatic logic win_ok(input logic [ADDR_W-1:0] a);
        win_ok = (a >> 9) == '0; // RQ15
    endfunction

    function automatic logic in_rng(input logic [6:0] i, input logic [6:0] lo, input logic [6:0] hi);
        in_rng = (i >= lo) && (i <= hi);
    endfunction

    // timing fields, decoded from length-minus-one codes
    assign presc = s_reg.bt0[BT0_PRE_LSB +: PRE_W]; // RQ6 RQ14
    assign time_segment_one_field = s_reg.bt1[BT1_TIME_SEGMENT_ONE_FIELD_LSB +: 4]; // RQ8 RQ11
    assign time_segment_two_field = s_reg.bt1[BT1_TIME_SEGMENT_TWO_FIELD_LSB +: 3]; // RQ9 RQ11
    assign sjwq = {3'h0, s_reg.bt0[BT0_SJW_LSB +: 2]} + 5'h01; // RQ10 RQ11
    assign bit_quanta = {1'b0, time_segment_one_field} + {2'h0, time_segment_two_field} + 5'h03;
    assign widx = awaddr[8:2];
    assign ridx = araddr[8:2];

    // engine stops in soft reset and in sleep; bus side goes recessive
    assign halt = s_reg.mc0[MC0_SOFT_RST] || internal_sleep;
    assign src_tick = s_reg.mc1[MC1_CLK_SRC] ? pll_tick : osc_tick; // RQ5
    assign tq_tick = src_tick && (s_reg.pre_cnt == presc); // RQ6
    assign rx_edge = s_reg.rx_prev && !s_reg.rx_sync;
    assign frame_seen = (frame_ok_rx || frame_ok_tx) && s_reg.synced && !halt;

    always_comb begin
        logic [4:0] lag;
        logic [4:0] rem;
        s_next = s_reg;
        lag = s_reg.tq_cnt + 5'h01;
        rem = s_reg.seg_len - s_reg.tq_cnt;
        // receive pin synchroniser
        s_next.rx_meta = can_receive_pin;
        s_next.rx_sync = s_reg.rx_meta;
        s_next.rx_prev = s_reg.rx_sync;

        // write channel: address and data are taken together, response follows
        s_next.awready = 1'b0;
        s_next.wready = 1'b0;
        if (awvalid && wvalid && !s_reg.awready && !s_reg.bvalid) begin
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        if (s_reg.awready) begin
            s_next.bvalid = 1'b1;
            s_next.bresp = win_ok(awaddr) ? RESP_OKAY : RESP_SLVERR;
            // timing and source registers are locked unless soft reset is set
            if (win_ok(awaddr) && wstrb[0]) begin
                if (widx == IDX_MC0) begin
                    s_next.mc0 = wdata[7:0];
                end else if (widx == IDX_MC1 && s_reg.mc0[MC0_SOFT_RST]) begin
                    s_next.mc1 = wdata[7:0];
                end else if (widx == IDX_BT0 && s_reg.mc0[MC0_SOFT_RST]) begin
                    s_next.bt0 = wdata[7:0];
                end else if (widx == IDX_BT1 && s_reg.mc0[MC0_SOFT_RST]) begin
                    s_next.bt1 = wdata[7:0];
                end else if (in_rng(widx, IDX_FILT_LO, IDX_FILT_HI) || in_rng(widx, IDX_TXB_LO, IDX_TXB_HI)) begin
                    s_next.mem[widx] = wdata[7:0]; // RQ16
                end
            end
        end else if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end

        // read channel; reserved and error counter entries read zero here
        s_next.arready = 1'b0;
        if (arvalid && !s_reg.arready && !s_reg.rvalid) begin
            s_next.arready = 1'b1;
        end
        if (s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = win_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
            s_next.rdata = 32'h00000000;
            if (!win_ok(araddr)) begin
                s_next.rdata = 32'h00000000;
            end else if (ridx == IDX_MC0) begin
                s_next.rdata[7:0] = s_reg.mc0;
            end else if (ridx == IDX_MC1) begin
                s_next.rdata[7:0] = s_reg.mc1;
            end else if (ridx == IDX_BT0) begin
                s_next.rdata[7:0] = s_reg.bt0;
            end else if (ridx == IDX_BT1) begin
                s_next.rdata[7:0] = s_reg.bt1;
            end else if (ridx == IDX_STAT) begin
                s_next.rdata[2:0] = {s_reg.link_act, s_reg.sampled, s_reg.synced};
            end else if (in_rng(ridx, IDX_ERR_LO, IDX_ERR_HI)) begin
                s_next.rdata = 32'h00000000;
            end else if (in_rng(ridx, IDX_FILT_LO, IDX_FILT_HI) || in_rng(ridx, IDX_RXB_LO, IDX_TXB_HI)) begin
                s_next.rdata[7:0] = s_reg.mem[ridx]; // RQ16
            end
        end else if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end

        // bit timing engine
        s_next.sample_pulse = 1'b0;
        if (halt) begin
            s_next.pre_cnt = '0;
            s_next.seg = SEG_SYNC;
            s_next.tq_cnt = 5'h00;
            s_next.resynced = 1'b0;
            s_next.can_tx = 1'b1;
            s_next.idle_cnt = 4'h0;
            s_next.synced = 1'b0; // RQ17
        end else begin
            if (src_tick) begin
                s_next.pre_cnt = tq_tick ? '0 : s_reg.pre_cnt + 1'b1; // RQ6
            end
            // one resync per bit: late edge stretches seg one, early edge cuts seg two
            if (rx_edge && !s_reg.resynced && s_reg.seg != SEG_SYNC) begin
                s_next.resynced = 1'b1;
                if (s_reg.seg == SEG_ONE) begin
                    s_next.seg_len = s_reg.seg_len + ((lag < sjwq) ? lag : sjwq); // RQ10
                end else begin
                    s_next.seg_len = s_reg.seg_len - ((rem < sjwq) ? rem : sjwq); // RQ10
                end
            end
            if (tq_tick) begin
                case (s_reg.seg)
                    SEG_SYNC: begin
                        // transmit point: drive only once joined to the bus
                        s_next.can_tx = (tx_active && s_reg.synced) ? tx_bit : 1'b1; // RQ12 RQ18
                        s_next.seg = SEG_ONE; // RQ7
                        s_next.tq_cnt = 5'h00;
                        s_next.seg_len = {1'b0, time_segment_one_field} + 5'h01; // RQ8
                        s_next.resynced = 1'b0;
                    end
                    SEG_ONE: begin
                        s_next.samp_sh = {s_reg.samp_sh[0], s_reg.rx_sync};
                        if (s_reg.tq_cnt + 5'h01 >= s_next.seg_len) begin
                            // sample point; triple mode votes over the last three quanta
                            if (s_reg.bt1[BT1_SAMP3]) begin
                                s_next.sampled = (s_reg.samp_sh[1] & s_reg.samp_sh[0])
                                    | (s_reg.samp_sh[1] & s_reg.rx_sync)
                                    | (s_reg.samp_sh[0] & s_reg.rx_sync); // RQ13
                            end else begin
                                s_next.sampled = s_reg.rx_sync; // RQ13
                            end
                            s_next.sample_pulse = 1'b1; // RQ18
                            s_next.seg = SEG_TWO;
                            s_next.tq_cnt = 5'h00;
                            s_next.seg_len = {2'h0, time_segment_two_field} + 5'h01; // RQ9
                        end else begin
                            s_next.tq_cnt = s_reg.tq_cnt + 5'h01;
                        end
                    end
                    SEG_TWO: begin
                        if (s_reg.tq_cnt + 5'h01 >= s_next.seg_len) begin
                            s_next.seg = SEG_SYNC;
                            s_next.tq_cnt = 5'h00;
                        end else begin
                            s_next.tq_cnt = s_reg.tq_cnt + 5'h01;
                        end
                    end
                    default: begin
                        s_next.seg = SEG_SYNC;
                    end
                endcase
            end
            // count recessive samples until the bus has been idle long enough
            if (s_next.sample_pulse && !s_reg.synced) begin
                if (!s_next.sampled) begin
                    s_next.idle_cnt = 4'h0;
                end else if (s_reg.idle_cnt == IDLE_BITS - 4'h1) begin
                    s_next.synced = 1'b1; // RQ17
                end else begin
                    s_next.idle_cnt = s_reg.idle_cnt + 4'h1;
                end
            end
        end

        // timer link pulse, one bit time long, counted in quanta
        if (halt) begin
            s_next.link_act = 1'b0;
        end else if (frame_seen) begin
            s_next.link_act = 1'b1; // RQ2 RQ3
            s_next.link_cnt = bit_quanta;
        end else if (s_reg.link_act && tq_tick) begin
            s_next.link_cnt = s_reg.link_cnt - 5'h01;
            if (s_reg.link_cnt == 5'h01) begin
                s_next.link_act = 1'b0;
            end
        end
        s_next.timer_link_out = s_next.link_act && s_reg.mc0[MC0_TLINK_EN]; // RQ4
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.mc0 <= MC0_RST;
            s_reg.mc1 <= MC1_RST;
            s_reg.bt0 <= BT0_RST;
            s_reg.bt1 <= BT1_RST;
            s_reg.rx_meta <= 1'b1;
            s_reg.rx_sync <= 1'b1;
            s_reg.rx_prev <= 1'b1;
            s_reg.seg <= SEG_SYNC;
            s_reg.can_tx <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // wake-up detector runs off the synchronised receive level
    cbt_wake_filter #(
        .FILT_CYC(WAKE_FILT_CYC)
    ) u_wake (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .rx_level(s_reg.rx_sync),
        .sleeping(internal_sleep),
        .filter_en(s_reg.mc1[MC1_WAKE_FILT]),
        .wake(wakeup)
    );

    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bresp = s_reg.bresp;
    assign bvalid = s_reg.bvalid;
    assign arready = s_reg.arready;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
    assign rvalid = s_reg.rvalid;
    assign can_transmit = s_reg.can_tx;
    assign sample_strobe = s_reg.sample_pulse;
    assign sampled_bit = s_reg.sampled;
    assign bus_synced = s_reg.synced;
    assign timer_link_out = s_reg.timer_link_out;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence sync_tick_s;
        s_reg.seg == SEG_SYNC && tq_tick && !halt;
    endsequence

    sequence enter_one_s;
        s_reg.seg == SEG_ONE && s_reg.tq_cnt == 5'h00;
    endsequence

    a_sync_one_tq: assert property (sync_tick_s |=> enter_one_s) // RQ7
        else $error("sync segment not one quantum");
    a_seg1_load: assert property ($rose(s_reg.seg == SEG_ONE) |-> s_reg.seg_len == {1'b0, $past(time_segment_one_field)} + 5'h01) // RQ8
        else $error("segment one length wrong");
    a_seg2_load: assert property ($rose(s_reg.seg == SEG_TWO) |-> s_reg.seg_len == {2'h0, $past(time_segment_two_field)} + 5'h01) // RQ9
        else $error("segment two length wrong");
    a_jump_limit: assert property (s_reg.seg == SEG_ONE |-> s_reg.seg_len <= {1'b0, time_segment_one_field} + sjwq + 5'h01) // RQ10
        else $error("segment one stretched past jump width");
    a_sample_end: assert property (s_reg.sample_pulse |-> $past(s_reg.seg) == SEG_ONE && s_reg.seg == SEG_TWO) // RQ13
        else $error("sample not at end of segment one");
    a_tx_point: assert property ($changed(s_reg.can_tx) && !$past(halt) |-> $past(s_reg.seg) == SEG_SYNC && $past(tq_tick)) // RQ12
        else $error("transmit bit changed off the transmit point");
    a_prescale_src: assert property (tq_tick |-> (s_reg.mc1[MC1_CLK_SRC] ? pll_tick : osc_tick) ##1 s_reg.pre_cnt == '0) // RQ5
        else $error("quantum tick not from selected source");
    a_link_start: assert property (frame_seen |=> s_reg.link_act && s_reg.link_cnt == $past(bit_quanta)) // RQ2
        else $error("timer link pulse not started after frame");
    a_link_gate: assert property (s_reg.timer_link_out |-> s_reg.link_act && $past(s_reg.mc0[MC0_TLINK_EN])) // RQ4
        else $error("timer link output without enable");
    a_idle_sync: assert property ($rose(s_reg.synced) |-> $past(s_reg.idle_cnt) == IDLE_BITS - 4'h1 && s_reg.sampled) // RQ17
        else $error("joined bus before eleven recessive bits");
    a_win_err: assert property (s_reg.arready && !win_ok(araddr) |=> s_reg.rvalid && s_reg.rresp == RESP_SLVERR) // RQ15
        else $error("address outside window not refused");
    a_rxbuf_ro: assert property (s_reg.awready && in_rng(widx, IDX_RXB_LO, IDX_RXB_HI) |=> s_reg.mem == $past(s_reg.mem)) // RQ16
        else $error("receive buffer written by software");
endmodule

// File: shared/cbt_pkg.sv
package cbt_pkg;
    // clock and wake-up filter timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WAKE_FILT_NS = 500;
    localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] IDLE_BITS = 4'hB;

    // register indexes; the byte address is four times the index
    localparam logic [6:0] IDX_MC0 = 7'h00;
    localparam logic [6:0] IDX_MC1 = 7'h01;
    localparam logic [6:0] IDX_BT0 = 7'h02;
    localparam logic [6:0] IDX_BT1 = 7'h03;
    localparam logic [6:0] IDX_STAT = 7'h04;
    localparam logic [6:0] IDX_ERR_LO = 7'h0E;
    localparam logic [6:0] IDX_ERR_HI = 7'h0F;
    localparam logic [6:0] IDX_FILT_LO = 7'h10;
    localparam logic [6:0] IDX_FILT_HI = 7'h17;
    localparam logic [6:0] IDX_RXB_LO = 7'h40;
    localparam logic [6:0] IDX_RXB_HI = 7'h4F;
    localparam logic [6:0] IDX_TXB_LO = 7'h50;
    localparam logic [6:0] IDX_TXB_HI = 7'h7F;

    // field positions
    localparam int MC0_SOFT_RST = 0;
    localparam int MC0_TLINK_EN = 3;
    localparam int MC1_WAKE_FILT = 2;
    localparam int MC1_CLK_SRC = 6;
    localparam int BT0_SJW_LSB = 6;
    localparam int BT0_PRE_LSB = 0;
    localparam int BT1_SAMP3 = 7;
    localparam int BT1_TIME_SEGMENT_TWO_FIELD_LSB = 4;
    localparam int BT1_TIME_SEGMENT_ONE_FIELD_LSB = 0;

    // values after reset
    localparam logic [7:0] MC0_RST = 8'h01;
    localparam logic [7:0] MC1_RST = 8'h00;
    localparam logic [7:0] BT0_RST = 8'h00;
    localparam logic [7:0] BT1_RST = 8'h23;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEG_SYNC = 3'h1,
        SEG_ONE = 3'h2,
        SEG_TWO = 3'h4
    } cbt_seg_t;
endpackage

// File: verilog/cbt_wake_filter.sv
`timescale 1ns/1ps
module cbt_wake_filter
    import cbt_pkg::*;
#(
    parameter int FILT_CYC = WAKE_FILT_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic rx_level,
    input wire logic sleeping,
    input wire logic filter_en,
    output logic wake
);
    typedef struct packed {
        logic [15:0] cnt;
        logic armed;
        logic wake;
    } cbt_wf_state_t;

    cbt_wf_state_t s_reg;
    cbt_wf_state_t s_next;
    logic [15:0] need;

    // unfiltered mode wakes on the first dominant sample
    assign need = filter_en ? 16'(FILT_CYC) : 16'h0001;

    // count consecutive dominant cycles; one pulse per dominant stretch
    always_comb begin
        s_next = s_reg;
        s_next.wake = 1'b0;
        if (!sleeping || rx_level) begin
            s_next.cnt = 16'h0000;
            s_next.armed = 1'b1;
        end else if (s_reg.armed) begin
            s_next.cnt = s_reg.cnt + 16'h0001;
            if (s_next.cnt >= need) begin
                s_next.wake = 1'b1; // RQ1
                s_next.armed = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wake = s_reg.wake;

    a_wake_filtered: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ1
        (s_reg.wake && $past(filter_en)) |-> $past(s_reg.cnt) == 16'(FILT_CYC - 1))
        else $error("wake-up raised before the filter time");
endmodule

// File: tb/cbt_can_node.sv
`timescale 1ns/1ps
// behavioural far-side node: open-collector bus, recessive through the pull-up
module cbt_can_node (
    input wire logic can_transmit,
    input wire logic node_dominant,
    output logic can_receive_pin
);
    // any dominant driver pulls the line low, so an idle bus always reads recessive
    assign can_receive_pin = can_transmit & ~node_dominant;
endmodule

// File: tb/can_bit_timing_timer_link_tb_top.sv
`timescale 1ns/1ps
module can_bit_timing_timer_link_tb_top
    import cbt_pkg::*;
;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic pll_tick = 1'b0, internal_sleep = 1'b0, tx_active = 1'b0, tx_bit = 1'b1;
    logic frame_ok_rx = 1'b0, frame_ok_tx = 1'b0, node_dominant = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, can_receive_pin, can_transmit;
    logic sample_strobe, sampled_bit, bus_synced, timer_link_out, wakeup;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic [7:0] rv [4] = '{MC0_RST, MC1_RST, BT0_RST, BT1_RST};
    logic [6:0] idx;
    logic [7:0] d;
    int bad_count = 0, checks_done = 0, wake_cnt = 0, w0, n, b, q, t1, t2, pre, src;

    cbt_top u_dut (.sys_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .osc_tick(1'b1), .pll_tick, .can_receive_pin, .internal_sleep, .tx_active, .tx_bit,
        .frame_ok_rx, .frame_ok_tx, .can_transmit, .sample_strobe, .sampled_bit, .bus_synced,
        .timer_link_out, .wakeup);
    cbt_can_node u_node (.can_transmit, .node_dominant, .can_receive_pin);

    always #2.5 sys_clk = ~sys_clk;
    // pll tick at half rate so the clock source choice shows in the bit length
    always @(posedge sys_clk) pll_tick <= ~pll_tick;
    always @(posedge sys_clk) if (wakeup === 1'b1) wake_cnt <= wake_cnt + 1;

    function automatic logic [11:0] ad(input logic [6:0] i);
        return {3'h0, i, 2'h0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // address and data offered together, each released at its own ready edge;
    // bready simply stays high, so back-to-back writes never toggle it in one step
    task automatic axw(input logic [11:0] a, input logic [7:0] v);
        bit a_ok;
        bit w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge sys_clk);
            if (!a_ok && awready === 1'b1) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        rsp = bresp;
    endtask

    task automatic axr(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
    endtask

    // timing registers only accept writes while soft reset holds the engine
    task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
        axw(ad(IDX_MC0), 8'h01);
        axw(ad(IDX_MC1), c1);
        axw(ad(IDX_BT0), c2);
        axw(ad(IDX_BT1), c3);
        axw(ad(IDX_MC0), 8'h00);
    endtask

    task automatic strobe();
        do @(posedge sys_clk); while (sample_strobe !== 1'b1);
    endtask

    // one frame-end pulse, then the length of the timer link pulse in cycles
    task automatic tl(input logic s, output int len);
        if (s) frame_ok_tx <= 1'b1;
        else frame_ok_rx <= 1'b1;
        @(posedge sys_clk);
        frame_ok_tx <= 1'b0;
        frame_ok_rx <= 1'b0;
        repeat (2) @(posedge sys_clk);
        len = 0;
        while (timer_link_out === 1'b1 && len < 5000) begin
            len++;
            @(posedge sys_clk);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // longest bit is 25 quanta of 8 cycles; the whole run needs well under this
    initial begin
        repeat (80000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        w0 = $urandom(32'h1AB7);
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        for (int k = 0; k < 4; k++) begin
            axr(ad(7'(k)));
            chk(rd, {24'h0, rv[k]});
        end
        axr(12'h200);
        chk(32'(rsp), 32'(RESP_SLVERR));
        idx = 7'($urandom_range(80, 127));
        d = 8'($urandom);
        axw(ad(idx), d);
        chk(32'(rsp), 32'(RESP_OKAY));
        axr(ad(idx));
        chk(rd, {24'h0, d});
        // a write without the low byte lane must leave the entry alone
        wstrb <= 4'hE;
        axw(ad(idx), ~d);
        wstrb <= 4'hF;
        axr(ad(idx));
        chk(rd, {24'h0, d});
        axw(12'h200, d);
        chk(32'(rsp), 32'(RESP_SLVERR));
        axw(ad(IDX_RXB_LO), d);
        axr(ad(IDX_RXB_LO));
        chk(rd, 32'h0);
        $display("test registers done");
        // first pass shortest segments, second longest, third random
        for (int i = 0; i < 3; i++) begin
            t1 = (i == 0) ? 3 : (i == 1) ? 15 : $urandom_range(3, 15);
            t2 = (i == 0) ? 1 : (i == 1) ? 7 : $urandom_range(1, 7);
            pre = $urandom_range(0, 3);
            src = i % 2;
            q = (pre + 1) * (src + 1);
            b = (t1 + t2 + 3) * q;
            // third pass also turns on triple sampling
            cfg(8'(src << MC1_CLK_SRC), 8'(($urandom_range(0, t2 < 3 ? t2 : 3) << 6) | pre),
                8'((t2 << 4) | t1 | ((i == 2) ? 128 : 0)));
            n = 0;
            while (bus_synced !== 1'b1) begin
                @(posedge sys_clk);
                n++;
            end
            chk(32'(n >= 10 * b && n <= 12 * b), 32'h1);
            strobe();
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (sample_strobe !== 1'b1);
            chk(32'(n), 32'(b));
            tx_bit <= 1'($urandom);
            tx_active <= 1'b1;
            repeat (3) strobe();
            chk(32'(sampled_bit), 32'(tx_bit));
            chk(32'(can_transmit), 32'(tx_bit));
            tx_active <= 1'b0;
            axw(ad(IDX_MC0), 8'(1 << MC0_TLINK_EN));
            tl(1'(i), n);
            chk(32'(n >= b - q && n <= b + q), 32'h1);
            axw(ad(IDX_MC0), 8'h00);
            tl(1'b0, n);
            chk(32'(n), 32'h0);
            $display("test timing %0d done", i);
        end
        cfg(8'(1 << MC1_WAKE_FILT), 8'h00, BT1_RST);
        internal_sleep <= 1'b1;
        repeat (4) @(posedge sys_clk);
        w0 = wake_cnt;
        node_dominant <= 1'b1;
        @(posedge sys_clk);
        node_dominant <= 1'b0;
        repeat (150) @(posedge sys_clk);
        chk(32'(wake_cnt - w0), 32'h0);
        node_dominant <= 1'b1;
        repeat (WAKE_FILT_CYC + 30) @(posedge sys_clk);
        node_dominant <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk(32'(wake_cnt > w0), 32'h1);
        internal_sleep <= 1'b0;
        $display("test wakeup done");
        end_of_test();
    end
endmodule
